// [dspm_partner.sv]
// dspm_partner: far-side serial device, async framer and mode 0 slave
`timescale 1ns/1ps
module dspm_partner (
  // system clock and the port's pins
  input wire logic clk,
  input wire logic txd,
  input wire logic line,
  input wire logic line_oe,
  // our drive onto the data line
  output logic drv
);
  logic txd_q = 1'b1;
  logic m0_en = 1'b0;
  logic [7:0] m0_tx = 8'h00;
  logic [7:0] m0_rx = 8'h00;
  initial drv = 1'b1;
  // mode 0: the port owns the shift clock, we only follow it
  always @(posedge clk) begin
    txd_q <= txd;
    if (line_oe && !txd_q && txd) begin
      m0_rx <= {line, m0_rx[7:1]};
    end
    // shifted-out bits refill inverted so a stale line never looks valid
    if (m0_en && txd_q && !txd) begin
      drv <= m0_tx[0];
      m0_tx <= {~m0_tx[0], m0_tx[7:1]};
    end
  end
  // bit 0 of the frame goes first; line returns to mark afterwards
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      drv <= bits[i];
      repeat (per) @(posedge clk);
    end
    drv <= 1'b1;
  endtask : send
  task automatic take(input int n, input int per, output logic [10:0] bits);
    int k;
    bits = '0;
    k = 0;
    while (txd === 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (per) @(posedge clk);
    end
  endtask : take
endmodule : dspm_partner

// [dspm_pkg.sv]
// dspm_pkg: shared constants and types of the dual serial port block
package dspm_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_P0_CTL = 8'h98;
  localparam logic [7:0] IDX_P0_DATA = 8'h99;
  localparam logic [7:0] IDX_P1_DATA = 8'h9A;
  localparam logic [7:0] IDX_T3_CTL = 8'hC4;
  localparam logic [7:0] IDX_P1_CTL = 8'hF8;
  localparam logic [7:0] IDX_PWR_CTL = 8'h87;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] T3_RST = 8'h00;
  localparam logic [1:0] PWR_RST = 2'h0;
  // port control fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MP = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI = 1;
  localparam int CTL_RI = 0;
  // power control and timer-3 control fields
  localparam int PWR_DBL = 7;
  localparam int PWR_VIEW = 6;
  localparam int T3_DBL = 7;
  localparam int T3_VIEW = 6;
  localparam int T3_BAUD_SOURCE_SELECT = 5;
  // timing: dividers of the system clock or of overflow events
  localparam int OVS = 16;
  localparam logic [3:0] M0_DIV_SLOW = 4'hC;
  localparam logic [3:0] M0_DIV_FAST = 4'h2;
  localparam int M2_DIV_SLOW = 64;
  localparam int M2_DIV_FAST = 32;
  localparam int TMR_DIV_SLOW = 32;
  localparam int TMR_DIV_FAST = 16;
  localparam logic [1:0] PRE_M2_SLOW = 2'(M2_DIV_SLOW / OVS - 1);
  localparam logic [1:0] PRE_M2_FAST = 2'(M2_DIV_FAST / OVS - 1);
  localparam logic [1:0] PRE_TMR_SLOW = 2'(TMR_DIV_SLOW / OVS - 1);
  localparam logic [1:0] PRE_TMR_FAST = 2'(TMR_DIV_FAST / OVS - 1);
  localparam logic [3:0] TK_MID = 4'h7;
  localparam logic [3:0] TK_LAST = 4'hF;
  localparam logic [3:0] M0_BITS = 4'h8;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_ASYNC = 2'b01,
    SH_SYNC_TX = 2'b10,
    SH_SYNC_RX = 2'b11
  } dspm_sh_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } dspm_rx_t;
endpackage : dspm_pkg

// [dspm_properties.sv]
// dspm_properties: port-level checks of the dual serial port block
`timescale 1ns/1ps
module dspm_properties
  import dspm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // serial pins
  input wire logic [1:0] rxd_out,
  input wire logic [1:0] rxd_oe,
  input wire logic [1:0] txd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable;
  wire [7:0] idx = paddr[9:2];
  wire hit = idx == IDX_P0_CTL || idx == IDX_P0_DATA || idx == IDX_P1_DATA
    || idx == IDX_T3_CTL || idx == IDX_P1_CTL || idx == IDX_PWR_CTL;
  wire mapped = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0 && hit;
  // shift clock low half: one cycle when fast, six when slow
  sequence s_fast; ##1 txd[0]; endsequence
  sequence s_slow; ##1 (!txd[0])[*5] ##1 txd[0]; endsequence
  property p_ready; pready; endproperty
  property p_err_phase; pslverr |-> acc; endproperty
  property p_err_bad; acc && !mapped |-> pslverr; endproperty
  property p_err_good; acc && mapped |-> !pslverr; endproperty
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_rd_upper; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  property p_m0_clk; $fell(txd[0]) && rxd_oe[0] |-> s_fast or s_slow; endproperty
  // data must not move on the edge the peripheral samples it
  property p_m0_dat; $rose(txd[0]) && rxd_oe[0] |-> $stable(rxd_out[0]); endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_phase: assert property (p_err_phase) else $error("stray pslverr");
  a_err_bad: assert property (p_err_bad) else $error("unmapped not refused");
  a_err_good: assert property (p_err_good) else $error("mapped refused");
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  a_m0_clk: assert property (p_m0_clk) else $error("shift clock low half");
  a_m0_dat: assert property (p_m0_dat) else $error("data moved at clock rise");
endmodule : dspm_properties

bind dspm_serial dspm_properties #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));

// [dspm_serial.sv]
// dspm_serial: two serial ports with an APB register slave
`timescale 1ns/1ps
module dspm_serial
  import dspm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // baud sources and address recogniser
  input wire logic timer1_overflow,
  input wire logic timer3_overflow,
  input wire logic [1:0] addr_match,
  // serial pins, index is the port number
  input wire logic [1:0] rxd_in,
  output wire logic [1:0] rxd_out,
  output wire logic [1:0] rxd_oe,
  output wire logic [1:0] txd
);

  // paddr[9:2] carries the register index, so a narrower bus cannot reach the map
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction : hit

  // bus decode
  wire [7:0] idx = paddr[9:2];
  wire upper_zero = (paddr >> 10) == '0;
  wire aligned = (paddr[1:0] == 2'b00) && upper_zero;
  wire sel_c0 = aligned && hit(idx, IDX_P0_CTL);
  wire sel_d0 = aligned && hit(idx, IDX_P0_DATA);
  wire sel_d1 = aligned && hit(idx, IDX_P1_DATA);
  wire sel_c1 = aligned && hit(idx, IDX_P1_CTL);
  wire sel_t3 = aligned && hit(idx, IDX_T3_CTL);
  wire sel_pw = aligned && hit(idx, IDX_PWR_CTL);
  wire mapped = sel_c0 || sel_d0 || sel_d1 || sel_c1 || sel_t3 || sel_pw;
  wire acc = psel && penable;
  wire wr = acc && pwrite && mapped;
  wire [7:0] wd = pwdata[7:0];

  // zero wait states, every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // shared control registers
  logic [7:0] t3_q;
  logic [1:0] pwr_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t3_q <= T3_RST;
      pwr_q <= PWR_RST;
    end else begin
      if (wr && sel_t3) t3_q <= wd;
      if (wr && sel_pw) pwr_q <= wd[7:6];
    end
  end

  // per-port views of the shared registers
  wire [7:0] ctl_rd [2];
  wire [7:0] rbuf_rd [2];
  wire wr_ctl [2];
  wire wr_dat [2];
  wire dbl [2];
  wire tmr_fast [2];
  wire view [2];
  wire ovf [2];
  assign wr_ctl[0] = wr && sel_c0;
  assign wr_ctl[1] = wr && sel_c1;
  assign wr_dat[0] = wr && sel_d0;
  assign wr_dat[1] = wr && sel_d1;
  assign dbl[0] = pwr_q[PWR_DBL - 6];
  assign dbl[1] = t3_q[T3_DBL];
  assign tmr_fast[0] = pwr_q[PWR_DBL - 6];
  assign tmr_fast[1] = 1'b1;
  assign view[0] = pwr_q[PWR_VIEW - 6];
  assign view[1] = t3_q[T3_VIEW];
  assign ovf[0] = t3_q[T3_BAUD_SOURCE_SELECT] ? timer3_overflow : timer1_overflow;
  assign ovf[1] = timer3_overflow;

  // read mux, data buffer read returns the receive register
  wire [7:0] rd8 =
    sel_c0 ? ctl_rd[0] :
    sel_c1 ? ctl_rd[1] :
    sel_d0 ? rbuf_rd[0] :
    sel_d1 ? rbuf_rd[1] :
    sel_t3 ? t3_q :
    sel_pw ? {pwr_q, 6'h00} : 8'h00;
  assign prdata = {24'h000000, rd8};

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] ctl_q;
    logic fe_q;
    logic [7:0] rbuf_q;
    logic [1:0] pre_q;
    dspm_sh_t sh_q;
    logic [10:0] shr_q;
    logic [3:0] bc_q;
    logic [3:0] tk_q;
    logic [3:0] sc_q;
    dspm_rx_t rx_q;
    logic [9:0] rsh_q;
    logic [3:0] rbc_q;
    logic [3:0] rtk_q;
    logic rxd_prev_q;
    logic txd_q;
    logic dout_q;
    logic doe_q;

    wire [1:0] mode = {ctl_q[CTL_MODE_HI], ctl_q[CTL_MODE_LO]};
    wire m0 = (mode == 2'b00);
    wire m2 = (mode == 2'b10);
    wire nine = mode[1];
    wire ri = ctl_q[CTL_RI];
    wire ren = ctl_q[CTL_REN];
    wire mp = ctl_q[CTL_MP];
    wire rxd = rxd_in[p];

    // oversampling tick, sixteen per async bit
    wire pre_ev = m2 ? 1'b1 : ovf[p];
    wire [1:0] pre_lim = m2 ? (dbl[p] ? PRE_M2_FAST : PRE_M2_SLOW) :
                         (tmr_fast[p] ? PRE_TMR_FAST : PRE_TMR_SLOW);
    wire tick = pre_ev && (pre_q == pre_lim);
    wire [1:0] pre_d = !pre_ev ? pre_q : (tick ? 2'b00 : pre_q + 2'b01);

    // mode 0 shift clock period in system clocks
    wire [3:0] m0_div = mp ? M0_DIV_FAST : M0_DIV_SLOW;
    wire [3:0] m0_half = m0_div >> 1;
    wire sc_end = (sc_q == m0_div - 4'h1);
    wire sc_smp = (sc_q == m0_half);
    wire in_sync = (sh_q == SH_SYNC_TX) || (sh_q == SH_SYNC_RX);
    wire [3:0] sc_d = (!in_sync || sc_end) ? 4'h0 : sc_q + 4'h1;

    // transmit and mode 0 sequencer
    wire tk_end = tick && (tk_q == TK_LAST);
    // no queue: a buffer write while the sequencer is busy is dropped
    wire st_sync_tx = (sh_q == SH_IDLE) && m0 && wr_dat[p];
    wire st_sync_rx = (sh_q == SH_IDLE) && m0 && !wr_dat[p] && ren && !ri;
    wire st_async = (sh_q == SH_IDLE) && !m0 && wr_dat[p];
    wire [10:0] frame = nine ? {1'b1, ctl_q[CTL_TB8], wd, 1'b0} :
                               {2'b11, wd, 1'b0};
    dspm_sh_t sh_d;
    logic [10:0] shr_d;
    logic [3:0] bc_d;
    logic [3:0] tk_d;
    logic ti_set;
    logic m0_done;
    always_comb begin
      sh_d = sh_q;
      shr_d = shr_q;
      bc_d = bc_q;
      tk_d = tk_q;
      ti_set = 1'b0;
      m0_done = 1'b0;
      case (sh_q)
        SH_IDLE: begin
          tk_d = 4'h0;
          if (st_async) begin
            sh_d = SH_ASYNC;
            shr_d = frame;
            bc_d = nine ? 4'hA : 4'h9;
          end else if (st_sync_tx) begin
            sh_d = SH_SYNC_TX;
            shr_d = {3'b111, wd};
            bc_d = M0_BITS;
          end else if (st_sync_rx) begin
            sh_d = SH_SYNC_RX;
            bc_d = M0_BITS;
          end
        end
        SH_ASYNC: begin
          if (tick) tk_d = tk_q + 4'h1;
          if (tk_end) begin
            shr_d = {1'b1, shr_q[10:1]};
            bc_d = bc_q - 4'h1;
            if (bc_q == 4'h1) ti_set = 1'b1;
            if (bc_q == 4'h0) sh_d = SH_IDLE;
          end
        end
        SH_SYNC_TX: begin
          if (sc_end) begin
            shr_d = {1'b1, shr_q[10:1]};
            bc_d = bc_q - 4'h1;
            if (bc_q == 4'h1) begin
              ti_set = 1'b1;
              sh_d = SH_IDLE;
            end
          end
        end
        SH_SYNC_RX: begin
          if (sc_smp) shr_d = {shr_q[10:8], rxd, shr_q[7:1]};
          if (sc_end) begin
            bc_d = bc_q - 4'h1;
            if (bc_q == 4'h1) begin
              m0_done = 1'b1;
              sh_d = SH_IDLE;
            end
          end
        end
        default: sh_d = SH_IDLE;
      endcase
    end

    // asynchronous receiver
    // a line found high again at mid start bit is noise and is dropped
    wire fall = rxd_prev_q && !rxd;
    wire rtk_end = tick && (rtk_q == TK_LAST);
    wire [3:0] rlast = nine ? 4'h9 : 4'h8;
    wire [9:0] rsh_n = {rxd, rsh_q[9:1]};
    dspm_rx_t rx_d;
    logic [3:0] rtk_d;
    logic [3:0] rbc_d;
    logic fin;
    always_comb begin
      rx_d = rx_q;
      rtk_d = rtk_q;
      rbc_d = rbc_q;
      fin = 1'b0;
      case (rx_q)
        RX_IDLE: begin
          rtk_d = 4'h0;
          rbc_d = 4'h0;
          if (!m0 && ren && fall) rx_d = RX_START;
        end
        RX_START: begin
          if (tick) rtk_d = rtk_q + 4'h1;
          if (tick && rtk_q == TK_MID) begin
            rtk_d = 4'h0;
            rx_d = rxd ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (tick) rtk_d = rtk_q + 4'h1;
          if (rtk_end) begin
            rbc_d = rbc_q + 4'h1;
            if (rbc_q == rlast) begin
              fin = 1'b1;
              rx_d = RX_IDLE;
            end
          end
        end
        default: rx_d = RX_IDLE;
      endcase
      if (m0 || !ren) rx_d = RX_IDLE;
    end

    // frame acceptance at mid stop bit
    wire [7:0] a_byte = nine ? rsh_n[7:0] : rsh_n[8:1];
    wire a_ninth = nine ? rsh_n[8] : rxd;
    wire a_ok = !ri && (!mp || (a_ninth && addr_match[p]));
    wire a_load = fin && a_ok;
    wire fe_set = fin && !rxd;

    // control register next value, hardware set wins over software clear
    logic [7:0] ctl_d;
    logic fe_d;
    always_comb begin
      ctl_d = ctl_q;
      fe_d = fe_q;
      if (wr_ctl[p]) begin
        ctl_d = view[p] ? {ctl_q[7], wd[6:0]} : wd;
        if (view[p]) fe_d = wd[7];
      end
      if (ti_set) ctl_d[CTL_TI] = 1'b1;
      if (m0_done || a_load) ctl_d[CTL_RI] = 1'b1;
      if (a_load) ctl_d[CTL_RB8] = a_ninth;
      if (fe_set) fe_d = 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ctl_q <= CTL_RST;
        fe_q <= 1'b0;
        rbuf_q <= DATA_RST;
        pre_q <= 2'b00;
        sh_q <= SH_IDLE;
        shr_q <= 11'h7FF;
        bc_q <= 4'h0;
        tk_q <= 4'h0;
        sc_q <= 4'h0;
      end else begin
        ctl_q <= ctl_d;
        fe_q <= fe_d;
        if (m0_done) rbuf_q <= shr_d[7:0];
        else if (a_load) rbuf_q <= a_byte;
        pre_q <= pre_d;
        sh_q <= sh_d;
        shr_q <= shr_d;
        bc_q <= bc_d;
        tk_q <= tk_d;
        sc_q <= sc_d;
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        rx_q <= RX_IDLE;
        rsh_q <= 10'h000;
        rbc_q <= 4'h0;
        rtk_q <= 4'h0;
        rxd_prev_q <= 1'b1;
      end else begin
        rx_q <= rx_d;
        if (rx_q == RX_BITS && rtk_end) rsh_q <= rsh_n;
        rbc_q <= rbc_d;
        rtk_q <= rtk_d;
        rxd_prev_q <= rxd;
      end
    end

    // pins registered; the shift clock idles high and is low in each first half
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        txd_q <= 1'b1;
        dout_q <= 1'b1;
        doe_q <= 1'b0;
      end else begin
        txd_q <= in_sync ? (sc_q >= m0_half) :
                 (sh_q == SH_ASYNC) ? shr_q[0] : 1'b1;
        dout_q <= shr_q[0];
        doe_q <= (sh_q == SH_SYNC_TX);
      end
    end

    assign txd[p] = txd_q;
    assign rxd_out[p] = dout_q;
    assign rxd_oe[p] = doe_q;
    assign ctl_rd[p] = {view[p] ? fe_q : ctl_q[7], ctl_q[6:0]};
    assign rbuf_rd[p] = rbuf_q;
  end

endmodule : dspm_serial

// [test_dual_serial_port_modes.sv]
// test_dual_serial_port_modes: self-checking bench of the serial block
`timescale 1ns/1ps
module test_dual_serial_port_modes
  import dspm_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic timer1_overflow = 1'b0;
  logic timer3_overflow = 1'b0;
  logic [1:0] addr_match = 2'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  wire logic [1:0] drv;
  wire logic [1:0] rxd_out;
  wire logic [1:0] rxd_oe;
  wire logic [1:0] txd;
  wire logic [1:0] rxd_in = (rxd_oe & rxd_out) | (~rxd_oe & drv);
  int bad_count = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic [31:0] ec;
  logic [10:0] fr;
  logic [7:0] d;
  logic [7:0] e;
  logic nb;
  logic [7:0] regs [6] = '{IDX_P0_CTL, IDX_P0_DATA, IDX_P1_DATA, IDX_T3_CTL, IDX_P1_CTL,
    IDX_PWR_CTL};
  logic ovf_ph = 1'b0;
  logic t1_on = 1'b1;
  logic t3_on = 1'b1;
  always #50 clk = ~clk;
  // both overflows pulse every second cycle, out of phase; either can be stopped
  always @(posedge clk) begin
    ovf_ph <= ~ovf_ph;
    timer1_overflow <= ~ovf_ph & t1_on;
    timer3_overflow <= ovf_ph & t3_on;
  end
  dspm_serial i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timer1_overflow(timer1_overflow), .timer3_overflow(timer3_overflow),
    .addr_match(addr_match), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  dspm_partner i_pt0 (.clk(clk), .txd(txd[0]), .line(rxd_in[0]), .line_oe(rxd_oe[0]),
    .drv(drv[0]));
  dspm_partner i_pt1 (.clk(clk), .txd(txd[1]), .line(rxd_in[1]), .line_oe(rxd_oe[1]),
    .drv(drv[1]));
  function automatic logic [10:0] frame(input logic [7:0] v, input logic b, input int n);
    return (n == 10) ? {2'b01, v, 1'b0} : {1'b1, b, v, 1'b0};
  endfunction : frame
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic stuck;
    bad_count++;
    give_verdict();
  endtask : stuck
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] v);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    if (pready !== 1'b1) stuck();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic poll(input logic [7:0] i, input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, i, 8'h00);
      k++;
    end while (q[b] !== 1'b1 && k < 200);
    if (q[b] !== 1'b1) stuck();
  endtask : poll
  initial begin
    void'($urandom(32'hAE1D));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 8'h00);
      check("reset value", q, 32'h0);
    end
    apb(1'b0, 8'h00, 8'h00);
    check("unmapped read", q, 32'h0);
    d = 8'($urandom);
    apb(1'b1, IDX_T3_CTL, d);
    apb(1'b0, IDX_T3_CTL, 8'h00);
    check("t3 control", q, {24'h0, d});
    $display("registers done");
    for (int s = 0; s < 2; s++) begin
      d = 8'($urandom);
      nb = 1'($urandom);
      apb(1'b1, IDX_T3_CTL, {s[0], 7'h00});
      apb(1'b1, IDX_P1_CTL, {4'h8, nb, 3'h0});
      apb(1'b1, IDX_P1_DATA, d);
      i_pt1.take(11, s ? 32 : 64, fr);
      check("mode 2 frame", 32'(fr), 32'(frame(d, nb, 11)));
      apb(1'b0, IDX_P1_CTL, 8'h00);
      check("transmit flag", 32'(q[1]), 32'h1);
    end
    $display("mode 2 transmit done");
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      apb(1'b1, IDX_PWR_CTL, {k[0], 7'h00});
      apb(1'b1, IDX_T3_CTL, {2'b00, k[1], 5'h00});
      // only the selected timer runs, so a wrong source stalls the frame
      t1_on <= !k[1];
      t3_on <= k[1];
      apb(1'b1, IDX_P0_CTL, 8'h40);
      apb(1'b1, IDX_P0_DATA, d);
      i_pt0.take(10, k[0] ? 32 : 64, fr);
      check("mode 1 frame", 32'(fr), 32'(frame(d, 1'b1, 10)));
    end
    t1_on <= 1'b1;
    t3_on <= 1'b1;
    $display("mode 1 transmit done");
    // plain, flag still set, filter closed, filter open
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      nb = (k > 1) | 1'($urandom);
      addr_match <= {k == 3, 1'b0};
      if (k != 1) begin
        ec = {24'h0, k > 1 ? 8'hF0 : 8'hD0};
        apb(1'b1, IDX_P1_CTL, ec[7:0]);
      end
      i_pt1.send(frame(d, nb, 11), 11, 32);
      if (k == 0 || k == 3) begin
        e = d;
        ec = ec | {29'h0, nb, 2'b01};
      end
      apb(1'b0, IDX_P1_DATA, 8'h00);
      check("mode 3 data", q, {24'h0, e});
      apb(1'b0, IDX_P1_CTL, 8'h00);
      check("mode 3 control", q, ec);
    end
    $display("mode 3 receive done");
    d = 8'($urandom);
    apb(1'b1, IDX_PWR_CTL, 8'h00);
    apb(1'b1, IDX_T3_CTL, 8'h00);
    apb(1'b1, IDX_P0_CTL, 8'h50);
    i_pt0.send(frame(d, 1'b1, 10), 10, 64);
    apb(1'b0, IDX_P0_DATA, 8'h00);
    check("mode 1 data", q, {24'h0, d});
    apb(1'b0, IDX_P0_CTL, 8'h00);
    check("mode 1 control", q, 32'h55);
    // low stop bit: still taken with the filter off, error shown at bit 7
    d = 8'($urandom);
    apb(1'b1, IDX_PWR_CTL, 8'h40);
    apb(1'b1, IDX_P0_CTL, 8'h50);
    i_pt0.send(frame(d, 1'b1, 10) & 11'h1FF, 10, 64);
    apb(1'b0, IDX_P0_DATA, 8'h00);
    check("bad stop data", q, {24'h0, d});
    apb(1'b0, IDX_P0_CTL, 8'h00);
    check("framing error view", q, 32'hD1);
    apb(1'b1, IDX_PWR_CTL, 8'h00);
    $display("mode 1 receive done");
    for (int s = 0; s < 2; s++) begin
      d = 8'($urandom);
      apb(1'b1, IDX_P0_CTL, {2'b00, s[0], 5'h00});
      apb(1'b1, IDX_P0_DATA, d);
      poll(IDX_P0_CTL, 1);
      check("mode 0 sent", {24'h0, i_pt0.m0_rx}, {24'h0, d});
    end
    d = 8'($urandom);
    i_pt0.m0_tx <= d;
    i_pt0.m0_en <= 1'b1;
    apb(1'b1, IDX_P0_CTL, 8'h10);
    poll(IDX_P0_CTL, 0);
    apb(1'b0, IDX_P0_DATA, 8'h00);
    check("mode 0 received", q, {24'h0, d});
    $display("mode 0 done");
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge clk);
    stuck();
  end
endmodule : test_dual_serial_port_modes
